// ===== pkg/tdsa_cfg.svh
// Constants of the standalone turbo-decoder control block.
// Assumes inclusion from the package and the core files only.
`ifndef TDSA_CFG_SVH
`define TDSA_CFG_SVH
`define TDSA_SLOT_W 6
`define TDSA_SLOTS_PER_BIT 5
`define TDSA_HALF_LO_POS 0
`define TDSA_HALF_HI_POS 32
`define TDSA_HALF_W 32
`define TDSA_IDX_W 15
`define TDSA_IDX_HW 16
`define TDSA_IDX_PER_DW 4
`define TDSA_SYM_PER_DW 2
`define TDSA_ADDR_W 15
`define TDSA_MAX_FRAME 20730
`define TDSA_ITER_W 6
`define TDSA_ITER_FIELD_W 5
`define TDSA_ITER_LIMIT 6'h20
`define TDSA_MIN_DEFAULT 6'h01
`define TDSA_PASS_DEFAULT 6'h01
`define TDSA_SNR_W 7
`define TDSA_SNR_MAX 7'h64
`define TDSA_CRC_W 32
`define TDSA_CRC_LEN_W 6
`define TDSA_DEC_W 32
`define TDSA_EXT_W 7
`endif

// ===== pkg/tdsa_pkg.sv
// Types of the standalone turbo-decoder control block.
// Assumes tdsa_cfg.svh on the include path.
`include "tdsa_cfg.svh"
package tdsa_pkg;
   typedef enum logic [2:0] {
      TDSA_IDLE = 3'h0,
      TDSA_LOAD = 3'h1,
      TDSA_MAP = 3'h3,
      TDSA_HARD = 3'h2,
      TDSA_CEVAL = 3'h6,
      TDSA_CHECK = 3'h7,
      TDSA_PAD = 3'h5,
      TDSA_DONE = 3'h4
   } tdsa_state_t;

   typedef struct packed {
      logic little_order;
      logic index_order;
      logic host_order;
   } tdsa_order_t;

   typedef struct packed {
      logic [`TDSA_ITER_FIELD_W-1:0] max_iter;
      logic [`TDSA_ITER_FIELD_W-1:0] min_iter;
      logic [`TDSA_SNR_W-1:0] snr_threshold;
      logic [`TDSA_CRC_LEN_W-1:0] check_poly_length;
      logic [`TDSA_ITER_FIELD_W-1:0] check_pass_count;
      logic [`TDSA_CRC_W-1:0] check_poly;
      logic [`TDSA_ADDR_W-1:0] frame_len;
      logic use_index_table;
      logic msb_first;
      tdsa_order_t byte_order_register;
   } tdsa_cfg_t;

   // Slots of one bit: systematic, parity 1, parity 2, interleaved 1, interleaved 2
   typedef struct packed {
      logic [`TDSA_SLOT_W-1:0] symbol_slot_four;
      logic [`TDSA_SLOT_W-1:0] slot_three;
      logic [`TDSA_SLOT_W-1:0] slot_two;
      logic [`TDSA_SLOT_W-1:0] slot_one;
      logic [`TDSA_SLOT_W-1:0] symbol_slot_zero;
   } tdsa_slots_t;

   typedef struct packed {
      logic [`TDSA_CRC_W-1:0] rem;
   } tdsa_crc_state_t;

   typedef struct packed {
      tdsa_state_t st;
      logic idx_phase;
      logic holding;
      logic [1:0] sub;
      logic [63:0] hold;
      logic [`TDSA_ADDR_W-1:0] addr;
      logic loaded;
      logic running;
      logic [`TDSA_ITER_W-1:0] iter;
      logic second;
      logic snr_prev;
      logic snr_ok;
      logic [`TDSA_ITER_W-1:0] crc_cnt;
      logic out_phase;
      logic pend;
      logic pend_last;
      logic fin;
      logic [4:0] bitcnt;
      logic [`TDSA_DEC_W-1:0] word;
      logic ovalid;
      logic wodd;
      logic sym_we;
      logic idx_we;
      logic [`TDSA_ADDR_W-1:0] wr_addr;
      tdsa_slots_t sym;
      logic [`TDSA_IDX_W-1:0] idx;
      logic map_start;
      logic crc_clr;
      logic done;
      logic [`TDSA_ITER_W-1:0] iter_out;
      logic dec_pass;
   } tdsa_core_state_t;
endpackage : tdsa_pkg

// ===== core/tdsa_crc.sv
// Serial CRC checker over hard decisions, programmable polynomial and length.
// Assumes bits arrive oldest first, the appended check bits last.
`timescale 1ns/1ns
`default_nettype none
`include "tdsa_cfg.svh"
module tdsa_crc (
   input wire logic clk,
   input wire logic rstn,
   input wire logic clr,
   input wire logic bit_en,
   input wire logic bit_in,
   input wire logic [`TDSA_CRC_W-1:0] poly,
   input wire logic [`TDSA_CRC_LEN_W-1:0] len,
   output logic pass
);
   tdsa_pkg::tdsa_crc_state_t s_q, s_d;
   logic [`TDSA_CRC_W-1:0] mask;
   logic top;
   logic fb;

   always_comb begin
      // Lengths past the top bit saturate to a full word
      if (len >= 6'h20) begin
         mask = 32'hFFFFFFFF;
      end else begin
         mask = (32'h1 << len) - 32'h1;
      end
      top = |(s_q.rem & (mask ^ (mask >> 1)));
      fb = top ^ bit_in;
      s_d = s_q;
      if (clr) begin
         s_d.rem = '0;
      end else if (bit_en) begin
         s_d.rem = ({s_q.rem[30:0], 1'b0} ^ (fb ? poly : 32'h0)) & mask;
      end
      pass = ((s_q.rem & mask) == 32'h0);
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   a_crc_clear_zero: assert property (clr |=> pass)
      else $error("crc remainder not cleared");
endmodule : tdsa_crc
`default_nettype wire

// ===== core/tdsa_core.sv
// Standalone turbo-decoder control: load, iterate MAP passes, stop test, pack decisions.
// Assumes a MAP engine and local memory on the same clock; the DMA side honours ready.
`timescale 1ns/1ns
`default_nettype none
`include "tdsa_cfg.svh"
module tdsa_core (
   input wire logic clk,
   input wire logic rstn,
   input wire tdsa_pkg::tdsa_cfg_t cfg,
   input wire logic autonomous_operation,
   input wire logic start,
   output logic busy,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [63:0] in_data,
   output logic sym_we,
   output logic idx_we,
   output logic [`TDSA_ADDR_W-1:0] wr_addr,
   output tdsa_pkg::tdsa_slots_t sym_data,
   output logic [`TDSA_IDX_W-1:0] idx_data,
   output logic map_start,
   output logic map_second,
   input wire logic map_done,
   input wire logic map_snr_over,
   output logic rd_en,
   output logic [`TDSA_ADDR_W-1:0] rd_addr,
   input wire logic [`TDSA_EXT_W-1:0] rd_ext,
   input wire logic [`TDSA_SLOT_W-1:0] rd_sys,
   output logic out_valid,
   input wire logic out_ready,
   output logic [`TDSA_DEC_W-1:0] out_data,
   output logic decode_done_event,
   output logic [`TDSA_ITER_W-1:0] iterations,
   output logic dec_pass
);
   tdsa_pkg::tdsa_core_state_t s_q, s_d;
   logic [`TDSA_ITER_W-1:0] max_eff;
   logic [`TDSA_ITER_W-1:0] min_raw;
   logic [`TDSA_ITER_W-1:0] min_eff;
   logic [`TDSA_ITER_W-1:0] pass_eff;
   logic snr_en;
   logic crc_en;
   logic crc_ok;
   logic crc_pass;
   logic crc_bit_en;
   logic at_max;
   logic early;
   logic stop;
   logic snr_hit;
   logic last_ent;
   logic dec_bit;
   logic [7:0] llr_sum;
   logic [4:0] pos;
   logic [`TDSA_HALF_W-1:0] half_lo;
   logic [`TDSA_HALF_W-1:0] half_hi;
   logic [`TDSA_IDX_HW-1:0] idx_hw [`TDSA_IDX_PER_DW];
   logic [1:0] idx_pos;
   logic [`TDSA_ITER_W-1:0] iter_next;

   // Effective limits from the raw fields
   always_comb begin
      max_eff = (cfg.max_iter == 5'h00) ? `TDSA_ITER_LIMIT : {1'b0, cfg.max_iter};
      min_raw = (cfg.min_iter == 5'h00) ? `TDSA_MIN_DEFAULT : {1'b0, cfg.min_iter};
      // A minimum above the maximum is clipped so the run still ends
      min_eff = (min_raw > max_eff) ? max_eff : min_raw;
      pass_eff = (cfg.check_pass_count == 5'h00) ? `TDSA_PASS_DEFAULT : {1'b0, cfg.check_pass_count};
      snr_en = (cfg.snr_threshold != 7'h00) && (cfg.snr_threshold <= `TDSA_SNR_MAX);
      crc_en = (cfg.check_poly_length != 6'h00);
      crc_ok = (s_q.crc_cnt >= pass_eff);
   end

   // Half that holds the earlier bit of each double-word
   always_comb begin
      if (cfg.byte_order_register.little_order) begin
         half_lo = in_data_hold_lo(s_q.hold, 1'b1);
         half_hi = in_data_hold_lo(s_q.hold, 1'b0);
      end else begin
         half_lo = in_data_hold_lo(s_q.hold, 1'b0);
         half_hi = in_data_hold_lo(s_q.hold, 1'b1);
      end
   end

   function automatic logic [`TDSA_HALF_W-1:0] in_data_hold_lo(input logic [63:0] dw, input logic low);
      in_data_hold_lo = low ? dw[`TDSA_HALF_LO_POS +: `TDSA_HALF_W] : dw[`TDSA_HALF_HI_POS +: `TDSA_HALF_W];
   endfunction : in_data_hold_lo

   // Halfwords of the held double-word, entry k at position k, k^2 or k^3
   for (genvar k = 0; k < `TDSA_IDX_PER_DW; k++) begin : g_idx
      logic [1:0] src;
      always_comb begin
         if (cfg.byte_order_register.host_order) begin
            src = 2'(k);
         end else if (cfg.byte_order_register.index_order) begin
            src = 2'(k) ^ 2'h3;
         end else begin
            src = 2'(k) ^ 2'h2;
         end
      end
      assign idx_hw[k] = s_q.hold[src * `TDSA_IDX_HW +: `TDSA_IDX_HW];
   end

   always_comb begin
      idx_pos = s_q.sub;
      // Hard decision is the sign of extrinsic plus systematic
      llr_sum = {rd_ext[6], rd_ext} + {{2{rd_sys[5]}}, rd_sys};
      dec_bit = llr_sum[7];
      pos = cfg.msb_first ? (5'h1F - s_q.bitcnt) : s_q.bitcnt;
      last_ent = (s_q.addr == (cfg.frame_len - 15'h0001));
      snr_hit = snr_en && map_snr_over;
      iter_next = s_q.iter + 6'h01;
      at_max = !s_q.second && (s_q.iter >= max_eff);
      early = (s_q.iter >= min_eff) && (snr_en || crc_en)
         && (!snr_en || s_q.snr_ok) && (!crc_en || crc_ok);
      stop = at_max || early;
   end

   always_comb begin
      s_d = s_q;
      s_d.sym_we = 1'b0;
      s_d.idx_we = 1'b0;
      s_d.map_start = 1'b0;
      s_d.crc_clr = 1'b0;
      s_d.done = 1'b0;
      rd_en = 1'b0;
      crc_bit_en = 1'b0;
      if (s_q.ovalid && out_ready) begin
         s_d.ovalid = 1'b0;
         s_d.word = '0;
      end
      // Decision read one cycle earlier arrives now
      if (s_q.pend) begin
         s_d.pend = 1'b0;
         if (s_q.out_phase) begin
            s_d.word[pos] = dec_bit;
            s_d.bitcnt = s_q.bitcnt + 5'h01;
            if (s_q.bitcnt == 5'h1F) begin
               s_d.ovalid = 1'b1;
               s_d.wodd = ~s_q.wodd;
            end
         end else begin
            crc_bit_en = 1'b1;
         end
      end
      unique case (s_q.st)
         tdsa_pkg::TDSA_IDLE: begin
            if (start && autonomous_operation) begin
               s_d = '0;
               s_d.st = tdsa_pkg::TDSA_LOAD;
            end
         end
         tdsa_pkg::TDSA_LOAD: begin
            if (!s_q.holding) begin
               if (in_valid) begin
                  s_d.hold = in_data;
                  s_d.holding = 1'b1;
                  s_d.sub = 2'h0;
               end
            end else begin
               s_d.wr_addr = s_q.addr;
               if (s_q.idx_phase) begin
                  s_d.idx_we = 1'b1;
                  s_d.idx = idx_hw[idx_pos][`TDSA_IDX_W-1:0];
               end else begin
                  s_d.sym_we = 1'b1;
                  // Reserved top two bits of each half are dropped
                  s_d.sym = s_q.sub[0] ? half_hi[29:0] : half_lo[29:0];
               end
               s_d.addr = s_q.addr + 15'h0001;
               s_d.sub = s_q.sub + 2'h1;
               if (s_q.sub == (s_q.idx_phase ? 2'h3 : 2'h1)) begin
                  s_d.holding = 1'b0;
               end
               // Slots past the frame end in the last double-word are ignored
               if (last_ent) begin
                  s_d.holding = 1'b0;
                  s_d.addr = '0;
                  if (!s_q.idx_phase && cfg.use_index_table) begin
                     s_d.idx_phase = 1'b1;
                  end else begin
                     s_d.loaded = 1'b1;
                     s_d.st = tdsa_pkg::TDSA_MAP;
                  end
               end
            end
         end
         tdsa_pkg::TDSA_MAP: begin
            if (!s_q.running) begin
               // Start a cycle after the last write so memory is settled
               s_d.map_start = 1'b1;
               s_d.running = 1'b1;
            end else if (map_done) begin
               s_d.running = 1'b0;
               s_d.snr_prev = snr_hit;
               s_d.snr_ok = snr_hit && s_q.snr_prev;
               s_d.st = tdsa_pkg::TDSA_CHECK;
               if (!s_q.second) begin
                  s_d.iter = iter_next;
                  if (crc_en && (iter_next >= min_eff)) begin
                     s_d.st = tdsa_pkg::TDSA_HARD;
                     s_d.out_phase = 1'b0;
                     s_d.addr = '0;
                     s_d.crc_clr = 1'b1;
                  end
               end
            end
         end
         tdsa_pkg::TDSA_HARD: begin
            if (!s_q.pend && !s_q.ovalid && !s_q.fin) begin
               rd_en = 1'b1;
               s_d.pend = 1'b1;
               s_d.pend_last = last_ent;
               s_d.addr = s_q.addr + 15'h0001;
               s_d.fin = last_ent;
            end
            if (s_q.pend && s_q.pend_last) begin
               s_d.fin = 1'b0;
               s_d.st = s_q.out_phase ? tdsa_pkg::TDSA_PAD : tdsa_pkg::TDSA_CEVAL;
            end
         end
         tdsa_pkg::TDSA_CEVAL: begin
            if (crc_pass) begin
               s_d.crc_cnt = (s_q.crc_cnt == 6'h3F) ? s_q.crc_cnt : s_q.crc_cnt + 6'h01;
            end else begin
               s_d.crc_cnt = '0;
            end
            s_d.st = tdsa_pkg::TDSA_CHECK;
         end
         tdsa_pkg::TDSA_CHECK: begin
            if (stop) begin
               s_d.st = tdsa_pkg::TDSA_HARD;
               s_d.out_phase = 1'b1;
               s_d.addr = '0;
               s_d.bitcnt = '0;
               s_d.dec_pass = early && crc_en && crc_ok;
            end else begin
               s_d.second = ~s_q.second;
               s_d.st = tdsa_pkg::TDSA_MAP;
            end
         end
         tdsa_pkg::TDSA_PAD: begin
            if (!s_q.ovalid) begin
               if (s_q.bitcnt != 5'h00) begin
                  s_d.ovalid = 1'b1;
                  s_d.wodd = ~s_q.wodd;
                  s_d.bitcnt = '0;
               end else if (s_q.wodd) begin
                  // Zero word keeps the word count even for the DMA side
                  s_d.ovalid = 1'b1;
                  s_d.wodd = 1'b0;
               end else begin
                  s_d.st = tdsa_pkg::TDSA_DONE;
               end
            end
         end
         tdsa_pkg::TDSA_DONE: begin
            s_d.done = 1'b1;
            s_d.iter_out = s_q.iter;
            s_d.st = tdsa_pkg::TDSA_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   tdsa_crc u_crc (
      .clk(clk),
      .rstn(rstn),
      .clr(s_q.crc_clr),
      .bit_en(crc_bit_en),
      .bit_in(dec_bit),
      .poly(cfg.check_poly),
      .len(cfg.check_poly_length),
      .pass(crc_pass)
   );

   assign busy = (s_q.st != tdsa_pkg::TDSA_IDLE);
   assign in_ready = (s_q.st == tdsa_pkg::TDSA_LOAD) && !s_q.holding;
   assign sym_we = s_q.sym_we;
   assign idx_we = s_q.idx_we;
   assign wr_addr = s_q.wr_addr;
   assign sym_data = s_q.sym;
   assign idx_data = s_q.idx;
   assign map_start = s_q.map_start;
   assign map_second = s_q.second;
   assign rd_addr = s_q.addr;
   assign out_valid = s_q.ovalid;
   assign out_data = s_q.word;
   assign decode_done_event = s_q.done;
   assign iterations = s_q.iter_out;
   assign dec_pass = s_q.dec_pass;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   sequence s_take_sym;
      in_valid && in_ready && !s_q.idx_phase;
   endsequence

   sequence s_continue;
      (s_q.st == tdsa_pkg::TDSA_CHECK) && !stop;
   endsequence

   a_start_after_load: assert property (map_start |-> s_q.loaded)
      else $error("map pass started before load complete");
   a_pass_switches: assert property (s_continue |=> ##1 map_start && (map_second != $past(map_second, 2)))
      else $error("second pass did not switch setting");
   a_sym_written: assert property (s_take_sym |-> ##2 sym_we)
      else $error("accepted symbol word not written");
   // Checked only while busy: settings may change between runs while stale state lingers
   a_iter_bounded: assert property (busy |-> s_q.iter <= max_eff)
      else $error("iteration count beyond maximum");
   a_done_after_out: assert property (decode_done_event |-> $past(s_q.st) == tdsa_pkg::TDSA_DONE && !out_valid)
      else $error("done raised before decisions drained");
   a_done_reaches_min: assert property (decode_done_event |=> iterations >= min_eff || iterations == max_eff)
      else $error("done before minimum iterations");
   a_snr_off_zero: assert property (busy && cfg.snr_threshold == 7'h00 |-> !s_q.snr_ok)
      else $error("snr check active at zero threshold");
   a_crc_restart: assert property ((s_q.st == tdsa_pkg::TDSA_CEVAL) && !crc_pass |=> s_q.crc_cnt == 6'h00)
      else $error("crc pass count not restarted");
   a_crc_needs_hard: assert property ((s_q.st == tdsa_pkg::TDSA_CEVAL) |-> $past(s_q.st) == tdsa_pkg::TDSA_HARD)
      else $error("crc evaluated without decisions");
   a_snr_two_hits: assert property (s_q.snr_ok |-> s_q.snr_prev)
      else $error("snr stop after single pass");
   a_count_shown: assert property ($rose(decode_done_event) |=> iterations == s_q.iter)
      else $error("iteration count not published");
endmodule : tdsa_core
`default_nettype wire

// ===== test/tdsa_map_model.sv
// Model of the MAP engine and the decision memory beside the control block.
// Assumes one clock shared with the block; pass latency is set by the bench.
`timescale 1ns/1ns
`default_nettype none
module tdsa_map_model (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [3:0] lat,
   input wire logic snr_hi,
   input wire logic map_start,
   output logic map_done,
   output logic map_snr_over,
   input wire logic rd_en,
   input wire logic [14:0] rd_addr,
   output logic [6:0] rd_ext,
   output logic [5:0] rd_sys
);
   logic [4:0] cnt_q;

   always_ff @(posedge clk) begin
      map_done <= 1'b0;
      // Flag means nothing outside done, so it is not held
      map_snr_over <= ~map_snr_over;
      if (!rstn) begin
         cnt_q <= 5'h00;
         map_snr_over <= 1'b0;
      end else if (map_start) begin
         cnt_q <= {1'b0, lat};
      end else if (cnt_q == 5'h01) begin
         cnt_q <= 5'h00;
         map_done <= 1'b1;
         map_snr_over <= snr_hi;
      end else if (cnt_q != 5'h00) begin
         cnt_q <= cnt_q - 5'h01;
      end
   end

   // Sum is negative on every third address
   always_ff @(posedge clk) begin
      if (rd_en) begin
         rd_ext <= (rd_addr % 15'h0003 == 15'h0000) ? 7'h7E : 7'h02;
         rd_sys <= 6'h01;
      end else begin
         rd_ext <= ~rd_ext;
         rd_sys <= ~rd_sys;
      end
   end
endmodule : tdsa_map_model
`default_nettype wire

// ===== test/tb_tdsa_core.sv
// Bench for the standalone turbo-decoder control: load, decode, packed decisions.
// Assumes the MAP engine model beside the block and a 10 MHz clock.
`timescale 1ns/1ns
`default_nettype none
module tb_tdsa_core;
   localparam int FL = 40;
   int ep[4] = '{3, 2, 11, 3};
   int ei[4] = '{2, 1, 6, 2};
   int lt[4] = '{2, 9, 4, 3};
   logic clk, rstn, autonomous_operation, start, busy, in_valid, in_ready;
   tdsa_pkg::tdsa_cfg_t cfg;
   tdsa_pkg::tdsa_slots_t sym_data;
   logic [63:0] in_data;
   logic sym_we, idx_we, map_start, map_second, map_done, map_snr_over, rd_en;
   logic [14:0] wr_addr, idx_data, rd_addr;
   logic [6:0] rd_ext;
   logic [5:0] rd_sys, iterations;
   logic out_valid, out_ready, decode_done_event, dec_pass, snr_hi;
   logic [31:0] out_data;
   logic [3:0] lat;
   int miscompares, n_checks, nwr, npass, nword;

   tdsa_core dut (.clk(clk), .rstn(rstn), .cfg(cfg), .autonomous_operation(autonomous_operation),
      .start(start), .busy(busy), .in_valid(in_valid), .in_ready(in_ready), .in_data(in_data),
      .sym_we(sym_we), .idx_we(idx_we), .wr_addr(wr_addr), .sym_data(sym_data), .idx_data(idx_data),
      .map_start(map_start), .map_second(map_second), .map_done(map_done),
      .map_snr_over(map_snr_over), .rd_en(rd_en), .rd_addr(rd_addr), .rd_ext(rd_ext),
      .rd_sys(rd_sys), .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data),
      .decode_done_event(decode_done_event), .iterations(iterations), .dec_pass(dec_pass));

   tdsa_map_model model (.clk(clk), .rstn(rstn), .lat(lat), .snr_hi(snr_hi),
      .map_start(map_start), .map_done(map_done), .map_snr_over(map_snr_over),
      .rd_en(rd_en), .rd_addr(rd_addr), .rd_ext(rd_ext), .rd_sys(rd_sys));

   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   task automatic end_of_test();
      if (miscompares == 0 && n_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : end_of_test

   task automatic timeout(input int t);
      if (t >= 5000) begin
         miscompares++;
         end_of_test();
      end
   endtask : timeout

   function automatic logic [29:0] syms(input int b);
      logic [29:0] v;
      for (int s = 0; s < 5; s++) v[6 * s +: 6] = 6'((b * 5 + s) % 64);
      return v;
   endfunction : syms

   function automatic logic [31:0] dword(input int w, input logic msb);
      logic [31:0] v;
      v = 32'h00000000;
      for (int i = 0; i < 32; i++)
         if (32 * w + i < FL && (32 * w + i) % 3 == 0) v[msb ? 31 - i : i] = 1'b1;
      return v;
   endfunction : dword

   // Holds valid high across words; each send drives it high again and waits for in_ready
   task automatic send(input logic [63:0] d);
      int t;
      t = 0;
      in_data <= d;
      in_valid <= 1'b1;
      do begin
         @(posedge clk);
         t++;
      end while (in_ready !== 1'b1 && t < 5000);
      timeout(t);
   endtask : send

   always @(posedge clk) begin
      if (sym_we) begin
         check("sym_data", 32'(sym_data), {2'h0, syms(nwr)});
         check("sym_addr", 32'(wr_addr), nwr);
         nwr++;
      end
      if (idx_we) begin
         check("idx_data", 32'(idx_data), (nwr - FL) * 3 + 1);
         check("idx_addr", 32'(wr_addr), nwr - FL);
         nwr++;
      end
      if (map_start) begin
         check("load_before_map", nwr, 2 * FL);
         check("pass_order", 32'(map_second), npass % 2);
         npass++;
      end
      if (out_valid && out_ready) begin
         check("dec_word", out_data, dword(nword, cfg.msb_first));
         nword++;
      end
      if (decode_done_event) check("words_before_done", nword, 2);
      out_ready <= ~out_ready;
   end

   task automatic run(input int r);
      tdsa_pkg::tdsa_cfg_t c;
      logic [63:0] d;
      int k;
      int t;
      c = '0;
      c.frame_len = 15'(FL);
      c.use_index_table = 1'b1;
      c.max_iter = r == 1 ? 5'h00 : 5'(2 * r + 2);
      c.min_iter = r == 1 ? 5'h01 : 5'h00;
      c.snr_threshold = r == 1 ? 7'h05 : r == 2 ? 7'h65 : 7'h00;
      // Length 2 with this polynomial never divides the pattern; length 1 is even parity and passes
      c.check_poly_length = r == 0 ? 6'h02 : r == 3 ? 6'h01 : 6'h00;
      c.check_poly = 32'h00000001;
      c.check_pass_count = r == 3 ? 5'h02 : 5'h00;
      c.msb_first = r != 1;
      c.byte_order_register.little_order = r != 1;
      c.byte_order_register.index_order = r == 2;
      c.byte_order_register.host_order = r == 0;
      @(posedge clk);
      cfg <= c;
      lat <= 4'(lt[r]);
      snr_hi <= 1'b1;
      nwr = 0;
      npass = 0;
      nword = 0;
      autonomous_operation <= 1'b1;
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      for (int b = 0; b < FL; b += 2)
         send(c.byte_order_register.little_order ? {2'h3, syms(b + 1), 2'h3, syms(b)}
            : {2'h3, syms(b), 2'h3, syms(b + 1)});
      for (int e = 0; e < FL / 4; e++) begin
         for (int q = 0; q < 4; q++) begin
            k = c.byte_order_register.host_order ? q : c.byte_order_register.index_order ? q ^ 3 : q ^ 2;
            d[16 * k +: 16] = {1'b1, 15'((4 * e + q) * 3 + 1)};
         end
         send(d);
      end
      in_valid <= 1'b0;
      t = 0;
      do begin
         @(posedge clk);
         t++;
      end while (decode_done_event !== 1'b1 && t < 5000);
      timeout(t);
      @(posedge clk);
      @(posedge clk);
      check("passes", npass, ep[r]);
      check("iterations", 32'(iterations), ei[r]);
      check("dec_pass", 32'(dec_pass), 32'(r == 3));
      check("busy", 32'(busy), 0);
   endtask : run

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   initial begin
      rstn = 1'b0;
      cfg = '0;
      autonomous_operation = 1'b0;
      start = 1'b0;
      in_valid = 1'b0;
      in_data = 64'h0000000000000000;
      out_ready = 1'b0;
      snr_hi = 1'b0;
      lat = 4'h2;
      miscompares = 0;
      n_checks = 0;
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      @(posedge clk);
      check("busy_idle", 32'(busy), 0);
      for (int r = 0; r < 4; r++) run(r);
      end_of_test();
   end
endmodule : tb_tdsa_core
`default_nettype wire
